/* include/sacr_pkg.sv */
// Package: constants and types for the sub-audio control and status register block
// Overview of operation
// RULE1: Mode 000 tone decode; 001 data decode
// RULE2: 010 tone enc, 011 data enc, 100 tone
// RULE3: 101 data enc plus tone dec; 110 decoders
// RULE4: 111 data decode, transmit lowpass stays active
// RULE5: Bit 4 enables audio, else mid rail
// RULE6: Bit 3 inserts bandstop filter, else bypass
// RULE7: Bit 2 enables all interrupt sources
// RULE8: Bit 1 selects 180Hz, zero selects 260Hz
// RULE9: Bit 0 powersaves all encoders and decoders
// RULE10: Host must general reset before trusting registers
// RULE11: Command 01 clears control, status, timer
// RULE12: General reset leaves data registers untouched
// RULE13: After general reset device enters tone decode
// RULE14: Status read is 71/79 plus reply byte
// RULE15: Status bits 0-5 set independently, raise request
// RULE16: Status read returns contents, releases request
// RULE17: Bit 5 tx done, cleared write/reset/powersave
// RULE18: Bit 4 tx ready, cleared write/reset/powersave
// RULE19: Bit 3 overrun, cleared rx read/reset/powersave
// RULE20: Bit 2 rx byte, cleared rx read/reset/powersave
// RULE21: Bit 1 notone expiry, cleared status read
// RULE22: Bit 0 tone measured, cleared status read
// RULE23: Control write is 70/78 plus one byte
// RULE24: Address select picks first or second device
// RULE25: Notone timeout one-shot, armed by tone measurement
// RULE26: Status bits 7 and 6 read zero
// RULE27: Request only when enabled and status nonzero
package sacr_pkg;
   localparam logic [7:0] CMD_RESET = 8'h01;
   localparam logic [7:0] CMD_CTRL_WR = 8'h70;
   localparam logic [7:0] CMD_STAT_RD = 8'h71;
   localparam logic [7:0] CMD_RXDATA_RD = 8'h74;
   localparam logic [7:0] CMD_TXDATA_WR = 8'h75;
   localparam logic [7:0] DEV2_OFFSET = 8'h08;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] STAT_USED = 8'h3f;
   localparam int BIT_TXDONE = 5;
   localparam int BIT_TXRDY = 4;
   localparam int BIT_OVR = 3;
   localparam int BIT_RXAV = 2;
   localparam int BIT_NOTONE = 1;
   localparam int BIT_TONE = 0;
   localparam logic [2:0] BYTE_LAST = 3'h7;

   typedef enum logic [2:0] {
      SACR_MODE_TONE_DEC = 3'b000,
      SACR_MODE_DATA_DEC = 3'b001,
      SACR_MODE_TONE_ENC = 3'b010,
      SACR_MODE_DATA_ENC = 3'b011,
      SACR_MODE_TONE_ENC_DEC = 3'b100,
      SACR_MODE_DENC_TDEC = 3'b101,
      SACR_MODE_BOTH_DEC = 3'b110,
      SACR_MODE_DATA_DEC_LP = 3'b111
   } sacr_mode_t;

   typedef struct packed {
      sacr_mode_t mode;
      logic audio_en;
      logic bandstop_en;
      logic irq_en;
      logic rx_bw_180;
      logic save_all;
   } sacr_ctrl_t;

   typedef struct packed {
      logic tone_dec;
      logic data_dec;
      logic tone_enc;
      logic data_enc;
      logic tx_low_pass_stage;
   } sacr_enables_t;

   typedef struct packed {
      logic tx_done;
      logic tx_ready;
      logic rx_byte;
      logic rx_overrun;
      logic notone;
      logic tone_done;
   } sacr_events_t;

   typedef enum logic [1:0] {
      SACR_ST_CMD = 2'b00,
      SACR_ST_CTRL = 2'b01,
      SACR_ST_REPLY = 2'b10,
      SACR_ST_SKIP = 2'b11
   } sacr_state_t;
endpackage

/* rtl/sacr_sync.sv */
// Two-flop synchroniser for one input from outside the clock domain
module sacr_sync (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic d,
   output logic q
);
   logic [1:0] s_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= 2'b00;
      end else begin
         s_q <= {s_q[0], d};
      end
   end
   assign q = s_q[1];
endmodule

/* rtl/sacr_regs.sv */
// Serial command decoder, control register and status register of the sub-audio processor
module sacr_regs (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic bus_sclk,
   input wire logic bus_cs_n,
   input wire logic bus_cmd,
   input wire logic addr_sel,
   input wire sacr_pkg::sacr_events_t ev,
   output logic bus_reply,
   output logic irq_n,
   output sacr_pkg::sacr_ctrl_t ctrl,
   output sacr_pkg::sacr_enables_t enables,
   output logic audio_mid_rail_level,
   output logic notone_discharge,
   output logic txdata_wr,
   output logic rxdata_rd
);
   typedef struct packed {
      sacr_pkg::sacr_state_t st;
      logic sclk_prev;
      logic [7:0] sh;
      logic [2:0] cnt;
      sacr_pkg::sacr_ctrl_t ctrl;
      logic [7:0] stat;
      logic [7:0] rep;
      logic armed;
      logic reply;
      logic irq_n;
      logic mid;
      logic dis;
      logic txw;
      logic rxr;
      sacr_pkg::sacr_enables_t en;
   } sacr_regs_t;

   sacr_regs_t r_q;
   sacr_regs_t r_d;
   logic sclk_s;
   logic cs_n_s;
   logic cmd_s;
   logic asel_s;
   logic sclk_rise;
   logic sclk_fall;
   logic [7:0] byte_in;
   logic [7:0] dev_off;
   logic byte_done;
   logic greset;
   logic ctrl_sel;
   logic stat_rd;
   logic rx_rd;
   logic tx_wr;
   logic ctrl_wr;
   logic [7:0] ev_set;
   logic [7:0] ev_clr;

   // Bus pins come from the host and are asynchronous to clk
   sacr_sync sacr_sync_sclk (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(bus_sclk),
      .q(sclk_s)
   );
   sacr_sync sacr_sync_cs (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(bus_cs_n),
      .q(cs_n_s)
   );
   sacr_sync sacr_sync_cmd (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(bus_cmd),
      .q(cmd_s)
   );
   sacr_sync sacr_sync_asel (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(addr_sel),
      .q(asel_s)
   );

   always_comb begin
      sclk_rise = sclk_s && !r_q.sclk_prev;
      sclk_fall = !sclk_s && r_q.sclk_prev;
      byte_in = {r_q.sh[6:0], cmd_s};
      byte_done = sclk_rise && !cs_n_s && (r_q.cnt == sacr_pkg::BYTE_LAST);
      // Second device answers the same commands, all but general reset moved up by a fixed step
      if (asel_s) begin
         dev_off = sacr_pkg::DEV2_OFFSET; // RULE24
      end else begin
         dev_off = 8'h00;
      end
      greset = 1'b0;
      ctrl_sel = 1'b0;
      stat_rd = 1'b0;
      rx_rd = 1'b0;
      tx_wr = 1'b0;
      ctrl_wr = 1'b0;
      if (byte_done && (r_q.st == sacr_pkg::SACR_ST_CMD)) begin
         // General reset reaches every device on the bus, so it carries no offset
         if (byte_in == sacr_pkg::CMD_RESET) begin
            greset = 1'b1; // RULE11
         end else if (byte_in == 8'(sacr_pkg::CMD_CTRL_WR + dev_off)) begin
            ctrl_sel = 1'b1; // RULE23
         end else if (byte_in == 8'(sacr_pkg::CMD_STAT_RD + dev_off)) begin
            stat_rd = 1'b1; // RULE14
         end else if (byte_in == 8'(sacr_pkg::CMD_RXDATA_RD + dev_off)) begin
            rx_rd = 1'b1;
         end else if (byte_in == 8'(sacr_pkg::CMD_TXDATA_WR + dev_off)) begin
            tx_wr = 1'b1;
         end
      end
      if (byte_done && (r_q.st == sacr_pkg::SACR_ST_CTRL)) begin
         ctrl_wr = 1'b1;
      end
   end

   always_comb begin
      ev_set = 8'h00;
      ev_set[sacr_pkg::BIT_TXDONE] = ev.tx_done; // RULE17
      ev_set[sacr_pkg::BIT_TXRDY] = ev.tx_ready; // RULE18
      ev_set[sacr_pkg::BIT_OVR] = ev.rx_overrun; // RULE19
      ev_set[sacr_pkg::BIT_RXAV] = ev.rx_byte; // RULE20
      // Notone only counts once a tone has been measured, and only once
      ev_set[sacr_pkg::BIT_NOTONE] = ev.notone && r_q.armed; // RULE21 RULE25
      ev_set[sacr_pkg::BIT_TONE] = ev.tone_done; // RULE22 RULE15
      ev_clr = 8'h00;
      ev_clr[sacr_pkg::BIT_TXDONE] = tx_wr || !r_q.en.data_enc || greset; // RULE17
      ev_clr[sacr_pkg::BIT_TXRDY] = tx_wr || !r_q.en.data_enc || greset; // RULE18
      ev_clr[sacr_pkg::BIT_OVR] = rx_rd || !r_q.en.data_dec || greset; // RULE19
      ev_clr[sacr_pkg::BIT_RXAV] = rx_rd || !r_q.en.data_dec || greset; // RULE20
      ev_clr[sacr_pkg::BIT_NOTONE] = stat_rd || !r_q.en.tone_dec || greset; // RULE21
      ev_clr[sacr_pkg::BIT_TONE] = stat_rd || !r_q.en.tone_dec || greset; // RULE22
   end

   always_comb begin
      r_d = r_q;
      r_d.sclk_prev = sclk_s;
      r_d.dis = greset; // RULE11
      r_d.txw = tx_wr;
      r_d.rxr = rx_rd;
      if (cs_n_s) begin
         // Deselect ends a frame wherever it stood, so a cut frame leaves no half byte
         r_d.st = sacr_pkg::SACR_ST_CMD;
         r_d.cnt = 3'h0;
         r_d.reply = 1'b0;
      end else if (sclk_rise) begin
         r_d.sh = byte_in;
         r_d.cnt = 3'(r_q.cnt + 3'h1);
         if (byte_done) begin
            case (r_q.st)
               sacr_pkg::SACR_ST_CMD: begin
                  if (ctrl_sel) begin
                     r_d.st = sacr_pkg::SACR_ST_CTRL;
                  end else if (stat_rd) begin
                     r_d.st = sacr_pkg::SACR_ST_REPLY;
                  end else begin
                     r_d.st = sacr_pkg::SACR_ST_SKIP;
                  end
               end
               sacr_pkg::SACR_ST_CTRL: begin
                  r_d.st = sacr_pkg::SACR_ST_SKIP;
               end
               default: begin
                  r_d.st = r_q.st;
               end
            endcase
         end
      end else if (sclk_fall && (r_q.st == sacr_pkg::SACR_ST_REPLY)) begin
         // Reply changes on the falling edge so it is settled at the host's rising edge
         r_d.reply = r_q.rep[7]; // RULE14
         r_d.rep = {r_q.rep[6:0], 1'b0};
      end
      if (stat_rd) begin
         r_d.rep = r_q.stat & sacr_pkg::STAT_USED; // RULE16
      end
      if (greset) begin
         r_d.ctrl = sacr_pkg::sacr_ctrl_t'(sacr_pkg::CTRL_RESET); // RULE11 RULE12 RULE13
      end else if (ctrl_wr) begin
         r_d.ctrl = sacr_pkg::sacr_ctrl_t'(byte_in); // RULE23 RULE6 RULE8
      end
      r_d.stat = ((r_q.stat & ~ev_clr) | ev_set) & sacr_pkg::STAT_USED; // RULE15 RULE26
      if (ev.tone_done) begin
         r_d.armed = 1'b1; // RULE25
      end else if (greset || ev_set[sacr_pkg::BIT_NOTONE]) begin
         r_d.armed = 1'b0;
      end
      r_d.en = '0;
      case (r_d.ctrl.mode)
         sacr_pkg::SACR_MODE_TONE_DEC: begin
            r_d.en.tone_dec = 1'b1; // RULE1
         end
         sacr_pkg::SACR_MODE_DATA_DEC: begin
            r_d.en.data_dec = 1'b1; // RULE1
         end
         sacr_pkg::SACR_MODE_TONE_ENC: begin
            r_d.en.tone_enc = 1'b1; // RULE2
            r_d.en.tx_low_pass_stage = 1'b1;
         end
         sacr_pkg::SACR_MODE_DATA_ENC: begin
            r_d.en.data_enc = 1'b1; // RULE2
            r_d.en.tx_low_pass_stage = 1'b1;
         end
         sacr_pkg::SACR_MODE_TONE_ENC_DEC: begin
            r_d.en.tone_enc = 1'b1; // RULE2
            r_d.en.tone_dec = 1'b1;
            r_d.en.tx_low_pass_stage = 1'b1;
         end
         sacr_pkg::SACR_MODE_DENC_TDEC: begin
            r_d.en.data_enc = 1'b1; // RULE3
            r_d.en.tone_dec = 1'b1;
            r_d.en.tx_low_pass_stage = 1'b1;
         end
         sacr_pkg::SACR_MODE_BOTH_DEC: begin
            r_d.en.tone_dec = 1'b1; // RULE3
            r_d.en.data_dec = 1'b1;
         end
         default: begin
            // Data decode with the transmit lowpass stage kept alive
            r_d.en.data_dec = 1'b1; // RULE4
            r_d.en.tx_low_pass_stage = 1'b1; // RULE4
         end
      endcase
      if (r_d.ctrl.save_all) begin
         r_d.en = '0; // RULE9
      end
      r_d.mid = !r_d.ctrl.audio_en; // RULE5
      r_d.irq_n = !(r_q.ctrl.irq_en && ((r_q.stat & sacr_pkg::STAT_USED) != 8'h00)); // RULE7 RULE27
      if (sys_rst) begin
         // Contents are unknown until a general reset; sys_rst only gives a known start
         r_d.st = sacr_pkg::SACR_ST_CMD; // RULE10
         r_d.sclk_prev = 1'b0;
         r_d.sh = 8'h00;
         r_d.cnt = 3'h0;
         r_d.ctrl = sacr_pkg::sacr_ctrl_t'(sacr_pkg::CTRL_RESET);
         r_d.stat = sacr_pkg::STAT_RESET;
         r_d.rep = 8'h00;
         r_d.armed = 1'b0;
         r_d.reply = 1'b0;
         r_d.irq_n = 1'b1;
         r_d.mid = 1'b1;
         r_d.dis = 1'b0;
         r_d.txw = 1'b0;
         r_d.rxr = 1'b0;
         r_d.en = '0;
         r_d.en.tone_dec = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      r_q <= r_d;
   end

   // Every output comes straight from the state register
   assign bus_reply = r_q.reply;
   assign irq_n = r_q.irq_n;
   assign ctrl = r_q.ctrl;
   assign enables = r_q.en;
   assign audio_mid_rail_level = r_q.mid;
   assign notone_discharge = r_q.dis;
   assign txdata_wr = r_q.txw;
   assign rxdata_rd = r_q.rxr;

   // Checks on the register behaviour
   AST_STAT_UNUSED_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // RULE26
      (r_q.stat & ~sacr_pkg::STAT_USED) == 8'h00)
      else $error("unused status bits are set");

   AST_IRQ_NEEDS_ENABLE: assert property (@(posedge clk) disable iff (sys_rst) // RULE7 RULE27
      !irq_n |-> $past(r_q.ctrl.irq_en))
      else $error("request raised while interrupts disabled");

   AST_IRQ_ON_STATUS: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
      $past(r_q.ctrl.irq_en) && $past(r_q.stat[sacr_pkg::BIT_TONE]) |-> !irq_n)
      else $error("status bit set but no request");

   AST_GRESET_CTRL: assert property (@(posedge clk) disable iff (sys_rst) // RULE11 RULE13
      $past(greset) |-> (r_q.ctrl == sacr_pkg::CTRL_RESET) && r_q.en.tone_dec)
      else $error("general reset did not restore tone decode");

   AST_SAVE_ALL_OFF: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
      r_q.ctrl.save_all |-> (r_q.en == '0))
      else $error("function enabled under global powersave");

   AST_NOTONE_ARMED: assert property (@(posedge clk) disable iff (sys_rst) // RULE25
      $rose(r_q.stat[sacr_pkg::BIT_NOTONE]) |-> $past(r_q.armed))
      else $error("notone flag set while unarmed");

   AST_STAT_READ_CLR: assert property (@(posedge clk) disable iff (sys_rst) // RULE22
      $past(stat_rd) && !$past(ev.tone_done) |-> !r_q.stat[sacr_pkg::BIT_TONE])
      else $error("status read left tone flag set");

   AST_MID_RAIL: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
      r_q.mid == !r_q.ctrl.audio_en)
      else $error("audio mid rail level wrong");

   // Main scenarios to see in simulation
   COV_CTRL_WRITE: cover property (@(posedge clk) disable iff (sys_rst)
      ctrl_wr);
   COV_STATUS_READ: cover property (@(posedge clk) disable iff (sys_rst)
      stat_rd);
   COV_IRQ_RAISED: cover property (@(posedge clk) disable iff (sys_rst)
      $fell(r_q.irq_n));
   COV_GENERAL_RESET: cover property (@(posedge clk) disable iff (sys_rst)
      greset);
endmodule

/* verif/sacr_host.sv */
// Host model on the serial command bus
module sacr_host (
   input wire logic clk,
   output logic bus_sclk,
   output logic bus_cs_n,
   output logic bus_cmd,
   input wire logic bus_reply
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {bus_sclk, bus_cs_n, bus_cmd} = 3'h2;
   // Clock idles low between frames; data line flips so a stale bit is never seen
   task automatic frame(input logic [7:0] ac, input logic [7:0] d, input bit two, output logic [7:0] r);
      logic [15:0] s;
      s = {ac, d};
      @(posedge clk) bus_cs_n <= 1'b0;
      for (int i = 15; i >= (two ? 0 : 8); i--) begin
         bus_cmd <= s[i];
         repeat (6) @(posedge clk);
         bus_sclk <= 1'b1;
         r[i % 8] = bus_reply;
         repeat (6) @(posedge clk);
         bus_sclk <= 1'b0;
      end
      repeat (12) @(posedge clk);
      bus_cs_n <= 1'b1;
      bus_cmd <= ~bus_cmd;
   endtask
endmodule

/* verif/test_sacr_regs.sv */
// Testbench for the control and status register block
module test_sacr_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, sys_rst = 1'b1, addr_sel = 1'b0, sclk, cs_n, cmd, reply, irq_n, mid, dis, dis_seen = 1'b0;
   sacr_pkg::sacr_events_t ev = '0;
   sacr_pkg::sacr_ctrl_t ctrl;
   sacr_pkg::sacr_enables_t enables;
   int failures = 0, total_checks = 0, cycles = 0;
   logic [7:0] rd;
   sacr_host sacr_host_i (.clk(clk), .bus_sclk(sclk), .bus_cs_n(cs_n), .bus_cmd(cmd), .bus_reply(reply));
   sacr_regs sacr_regs_i (.clk(clk), .sys_rst(sys_rst), .bus_sclk(sclk), .bus_cs_n(cs_n), .bus_cmd(cmd),
      .addr_sel(addr_sel), .ev(ev), .bus_reply(reply), .irq_n(irq_n), .ctrl(ctrl), .enables(enables),
      .audio_mid_rail_level(mid), .notone_discharge(dis), .txdata_wr(), .rxdata_rd());
   initial forever #2 clk = ~clk;
   always @(posedge clk) if (dis) dis_seen <= 1'b1;
   always @(posedge clk) if (++cycles == 20000) begin failures++; complete_run(); end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin failures++; $display("unexpected at %0t: %h not %h", $time, seen, exp); end
   endtask
   task automatic io(input logic [7:0] ac, input logic [7:0] d, input bit two);
      sacr_host_i.frame(ac, d, two, rd);
      repeat (8) @(posedge clk);
   endtask
   task automatic pulse_tone;
      @(posedge clk) ev.tone_done <= 1'b1;
      @(posedge clk) ev.tone_done <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic t_reset;
      io(8'h70, 8'hf5, 1'b1);
      io(8'h01, 8'h00, 1'b0);
      check(ctrl, 8'h00);
      check({7'h0, dis_seen}, 8'h01);
      check({3'h0, enables[4:1], 1'b0}, 8'h10);
      $display("reset done");
   endtask
   task automatic t_modes;
      // Expected decoder and encoder enables per mode, four bits each
      logic [31:0] tbl = 32'h4c9a1248;
      for (int m = 0; m < 8; m++) begin
         io(8'h70, {m[2:0], 5'h0a}, 1'b1);
         check(ctrl, {m[2:0], 5'h0a});
         check({7'h0, mid}, 8'h01);
         check({4'h0, enables[4:1]}, {4'h0, tbl[m*4+:4]});
      end
      io(8'h70, 8'h61, 1'b1);
      check({4'h0, enables[4:1]}, 8'h00);
      $display("modes done");
   endtask
   task automatic t_irq;
      addr_sel <= 1'b1;
      io(8'h78, 8'h04, 1'b1);
      pulse_tone();
      check({7'h0, irq_n}, 8'h00);
      io(8'h79, 8'h00, 1'b1);
      check(rd, 8'h01);
      check({7'h0, irq_n}, 8'h01);
      io(8'h78, 8'h00, 1'b1);
      pulse_tone();
      check({7'h0, irq_n}, 8'h01);
      $display("irq done");
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_modes();
      t_irq();
      complete_run();
   end
endmodule
